// >>> rtl/ssr_consts.vh
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH
// ************************************************************
// Register offsets.
// ************************************************************
`define SSR_A_IRQ_EN   8'h00
`define SSR_A_IRQ_FLG  8'h04
`define SSR_A_RX_DATA  8'h08
`define SSR_A_RX_CTL   8'h0c
`define SSR_A_TX_CTL   8'h10
`define SSR_A_TX_BUF   8'h14
`define SSR_A_BAUD     8'h18
`define SSR_A_IRQ_CTL  8'h1c
// ************************************************************
// Field positions.
// ************************************************************
`define SSR_RC_SERIAL_PORT_ENABLE    7
`define SSR_RC_RX9     6
`define SSR_RC_SINGLE_RECEIVE_ENABLE    5
`define SSR_RC_CONTINUOUS_RECEIVE_ENABLE    4
`define SSR_RC_ADDRESS_DETECT_ENABLE   3
`define SSR_RC_OVERRUN_FLAG    1
`define SSR_RC_RECEIVED_NINTH_BIT    0
`define SSR_TC_CLOCK_SOURCE_SELECT    7
`define SSR_TC_TX9     6
`define SSR_TC_TRANSMIT_ENABLE    5
`define SSR_TC_SYNC    4
`define SSR_TC_BAUD_SPEED_SELECT    2
`define SSR_TC_TRMT    1
`define SSR_TC_TRANSMIT_NINTH_BIT    0
`define SSR_IF_RC      5
`define SSR_IF_TX      4
`define SSR_IC_GIE     7
`define SSR_IC_PERIPHERAL_IRQ_MASTER_ENABLE    6
// ************************************************************
// Reset values and counts.
// ************************************************************
`define SSR_RST_BYTE   8'h00
`define SSR_RST_CHAR   9'h000
`define SSR_RST_WORD   32'h00000000
`define SSR_RST_CNT    4'h0
`define SSR_BITS8      4'h8
`define SSR_BITS9      4'h9
`define SSR_ONE_CNT    4'h1
`define SSR_ONE_BYTE   8'h01
`endif

// >>> rtl/ssr_sync2.v
`timescale 1ns/10ps
module ssr_sync2 (
  input  wire sys_clk,
  input  wire rstn,
  input  wire din,
  output wire dout
);
  reg meta;
  reg stable;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta   <= 1'b0;
      stable <= 1'b0;
    end else begin
      meta   <= din;
      stable <= meta;
    end
  end

  assign dout = stable;
endmodule

// >>> rtl/ssr_rx_fifo.v
`timescale 1ns/10ps
`include "ssr_consts.vh"
module ssr_rx_fifo (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       flush,
  input  wire       push,
  input  wire [8:0] push_data,
  input  wire       pop,
  output wire [8:0] head,
  output wire       full,
  output wire       empty
);
  reg [8:0] slot [0:1];
  reg       rd_idx;
  reg       wr_idx;
  reg [1:0] level;

  // ************************************************************
  // Two-entry store; a push on a full store is dropped.
  // ************************************************************
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slot[0] <= `SSR_RST_CHAR;
      slot[1] <= `SSR_RST_CHAR;
      rd_idx  <= 1'b0;
      wr_idx  <= 1'b0;
      level   <= 2'h0;
    end else if (flush) begin
      rd_idx <= 1'b0;
      wr_idx <= 1'b0;
      level  <= 2'h0;
    end else begin
      if (push && !full) begin
        slot[wr_idx] <= push_data;
        wr_idx       <= ~wr_idx;
      end
      if (pop && !empty) begin
        rd_idx <= ~rd_idx;
      end
      if ((push && !full) && !(pop && !empty)) begin
        level <= level + 2'h1;
      end else if (!(push && !full) && (pop && !empty)) begin
        level <= level - 2'h1;
      end
    end
  end

  assign head  = slot[rd_idx];
  assign full  = level[1];
  assign empty = (level == 2'h0);
endmodule

// >>> rtl/ssr_port.v
`timescale 1ns/10ps
`include "ssr_consts.vh"
// Contract
// - master receive releases the data pin driver
// - either receive enable starts master reception; slave needs continuous
// - single receive clocks one character, self clears
// - continuous clocks until cleared; clear aborts character
// - both set in master: single clears, continuous continues
// - sample data on trailing clock edge
// - full character enters FIFO, ready flag set
// - data register shows oldest character low byte
// - slave releases clock pin, shifts on external clock
// - third character on full FIFO sets overrun
// - overrun blocks new characters, FIFO stays readable
// - overrun cleared by data read after single, by continuous clear after continuous
// - port enable clear resets the port logic
// - nine-bit mode shifts nine, ninth bit readable
// - control bits select sync, master, direction, enable
// - two buffer writes keep transmit flag clear
// - transmit flag with enables raises wake interrupt
// - buffer write loads empty shifter one cycle after the buffer fills
module ssr_port (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        bidir_data_pin_in,
  output reg         bidir_data_pin_out,
  output wire        bidir_data_pin_oe,
  input  wire        serial_clock_pin_in,
  output reg         serial_clock_pin_out,
  output wire        serial_clock_pin_oe,
  output wire        irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_HIGH = 3'b010;
  localparam ST_LOW  = 3'b100;

  reg [7:0] peripheral_irq_enable;
  reg       global_irq_enable;
  reg       peripheral_irq_master_enable;
  reg [7:0] baud_divider;
  reg       serial_port_enable;
  reg       nine_bit_receive_select;
  reg       single_receive_enable;
  reg       continuous_receive_enable;
  reg       address_detect_enable;
  reg       overrun_flag;
  reg       overrun_single;
  reg       clock_source_select;
  reg       nine_bit_transmit_select;
  reg       transmit_enable;
  reg       sync_select;
  reg       baud_speed_select;
  reg       transmit_ninth_bit;
  reg [8:0] transmit_buffer;
  reg       tx_buf_full;
  reg [8:0] transmit_shift_register;
  reg       tsr_full;
  reg [8:0] receive_shift_register;
  reg [3:0] bit_cnt;
  reg [2:0] state;
  reg [7:0] half_cnt;
  reg       clk_prev;
  reg [31:0] next_prdata;

  wire       data_s;
  wire       clk_s;
  wire [8:0] fifo_head;
  wire       fifo_full;
  wire       fifo_empty;

  // ************************************************************
  // Helper functions.
  // ************************************************************
  function [3:0] char_bits;
    input nine;
    begin
      char_bits = nine ? `SSR_BITS9 : `SSR_BITS8;
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  ssr_sync2 u_sync_data (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (bidir_data_pin_in),
    .dout    (data_s)
  );

  ssr_sync2 u_sync_clk (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (serial_clock_pin_in),
    .dout    (clk_s)
  );

  // ************************************************************
  // Bus decode.
  // ************************************************************
  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire mapped = hit(paddr, `SSR_A_IRQ_EN) || hit(paddr, `SSR_A_IRQ_FLG) ||
                hit(paddr, `SSR_A_RX_DATA) || hit(paddr, `SSR_A_RX_CTL) ||
                hit(paddr, `SSR_A_TX_CTL) || hit(paddr, `SSR_A_TX_BUF) ||
                hit(paddr, `SSR_A_BAUD) || hit(paddr, `SSR_A_IRQ_CTL);
  wire wr_rxc = wr_acc && hit(paddr, `SSR_A_RX_CTL);
  wire wr_txc = wr_acc && hit(paddr, `SSR_A_TX_CTL);
  wire wr_buf = wr_acc && hit(paddr, `SSR_A_TX_BUF);
  wire rd_dat = rd_acc && hit(paddr, `SSR_A_RX_DATA);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ************************************************************
  // Mode and bit-event decode.
  // ************************************************************
  wire sync_on   = serial_port_enable && sync_select;
  wire rx_mode   = single_receive_enable || continuous_receive_enable;
  wire master    = clock_source_select;
  wire rx_go     = sync_on && !overrun_flag &&
                   (master ? rx_mode : continuous_receive_enable);
  wire tx_go     = sync_on && !rx_mode && transmit_enable && tsr_full;
  wire active    = rx_mode ? rx_go : tx_go;
  wire [3:0] nbits = char_bits(rx_mode ? nine_bit_receive_select : nine_bit_transmit_select);
  wire m_tick    = (half_cnt == `SSR_RST_BYTE);
  wire m_lead    = master && ((state == ST_IDLE) || ((state == ST_LOW) && m_tick));
  wire m_trail   = master && (state == ST_HIGH) && m_tick;
  wire s_lead    = !master && clk_s && !clk_prev;
  wire s_trail   = !master && !clk_s && clk_prev;
  wire lead      = active && (m_lead || s_lead);
  wire trail     = active && (m_trail || s_trail);
  wire char_done = trail && (bit_cnt == (nbits - `SSR_ONE_CNT));
  wire [8:0] next_rsr = {data_s, receive_shift_register[8:1]};
  wire [8:0] rx_char  = nine_bit_receive_select ? next_rsr :
                        {1'b0, next_rsr[8:1]};
  wire rx_done   = char_done && rx_mode;
  wire rx_push   = rx_done && !fifo_full;
  wire overrun   = rx_done && fifo_full;
  wire tx_done   = char_done && !rx_mode;
  wire tx_load   = tx_buf_full && (!tsr_full || tx_done);
  wire receive_ready_flag      = !fifo_empty;
  wire transmit_ready_flag      = sync_on && transmit_enable && !tx_buf_full;

  assign bidir_data_pin_oe   = sync_on && !rx_mode && transmit_enable;
  assign serial_clock_pin_oe = sync_on && master;
  assign irq = peripheral_irq_master_enable &&
               ((transmit_ready_flag && peripheral_irq_enable[`SSR_IF_TX]) ||
                (receive_ready_flag && peripheral_irq_enable[`SSR_IF_RC]));

  ssr_rx_fifo u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .flush     (!serial_port_enable),
    .push      (rx_push),
    .push_data (rx_char),
    .pop       (rd_dat),
    .head      (fifo_head),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  // ************************************************************
  // Control registers.
  // ************************************************************
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      peripheral_irq_enable        <= `SSR_RST_BYTE;
      global_irq_enable            <= 1'b0;
      peripheral_irq_master_enable <= 1'b0;
      baud_divider                 <= `SSR_RST_BYTE;
      serial_port_enable           <= 1'b0;
      nine_bit_receive_select      <= 1'b0;
      single_receive_enable        <= 1'b0;
      continuous_receive_enable    <= 1'b0;
      address_detect_enable        <= 1'b0;
      clock_source_select          <= 1'b0;
      nine_bit_transmit_select     <= 1'b0;
      transmit_enable              <= 1'b0;
      sync_select                  <= 1'b0;
      baud_speed_select            <= 1'b0;
      transmit_ninth_bit           <= 1'b0;
    end else begin
      if (wr_acc && hit(paddr, `SSR_A_IRQ_EN)) begin
        peripheral_irq_enable <= pwdata[7:0];
      end
      if (wr_acc && hit(paddr, `SSR_A_IRQ_CTL)) begin
        global_irq_enable            <= pwdata[`SSR_IC_GIE];
        peripheral_irq_master_enable <= pwdata[`SSR_IC_PERIPHERAL_IRQ_MASTER_ENABLE];
      end
      if (wr_acc && hit(paddr, `SSR_A_BAUD)) begin
        baud_divider <= pwdata[7:0];
      end
      if (wr_rxc) begin
        serial_port_enable        <= pwdata[`SSR_RC_SERIAL_PORT_ENABLE];
        nine_bit_receive_select   <= pwdata[`SSR_RC_RX9];
        single_receive_enable     <= pwdata[`SSR_RC_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable <= pwdata[`SSR_RC_CONTINUOUS_RECEIVE_ENABLE];
        address_detect_enable     <= pwdata[`SSR_RC_ADDRESS_DETECT_ENABLE];
      end else if (rx_done && master) begin
        single_receive_enable <= 1'b0;
      end
      if (wr_txc) begin
        clock_source_select      <= pwdata[`SSR_TC_CLOCK_SOURCE_SELECT];
        nine_bit_transmit_select <= pwdata[`SSR_TC_TX9];
        transmit_enable          <= pwdata[`SSR_TC_TRANSMIT_ENABLE];
        sync_select              <= pwdata[`SSR_TC_SYNC];
        baud_speed_select        <= pwdata[`SSR_TC_BAUD_SPEED_SELECT];
        transmit_ninth_bit       <= pwdata[`SSR_TC_TRANSMIT_NINTH_BIT];
      end
    end
  end

  // ************************************************************
  // Overrun flag.
  // ************************************************************
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      overrun_flag   <= 1'b0;
      overrun_single <= 1'b0;
    end else if (!serial_port_enable) begin
      overrun_flag   <= 1'b0;
      overrun_single <= 1'b0;
    end else if (overrun) begin
      overrun_flag   <= 1'b1;
      overrun_single <= !continuous_receive_enable;
    end else if (overrun_flag) begin
      if (overrun_single ? rd_dat : !continuous_receive_enable) begin
        overrun_flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Master clock generator.
  // ************************************************************
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state                <= ST_IDLE;
      half_cnt             <= `SSR_RST_BYTE;
      serial_clock_pin_out <= 1'b0;
    end else if (!active || !master) begin
      state                <= ST_IDLE;
      half_cnt             <= `SSR_RST_BYTE;
      serial_clock_pin_out <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          state                <= ST_HIGH;
          half_cnt             <= baud_divider;
          serial_clock_pin_out <= 1'b1;
        end
        ST_HIGH: begin
          if (m_tick) begin
            state                <= ST_LOW;
            half_cnt             <= baud_divider;
            serial_clock_pin_out <= 1'b0;
          end else begin
            half_cnt <= half_cnt - `SSR_ONE_BYTE;
          end
        end
        ST_LOW: begin
          if (m_tick) begin
            state                <= ST_HIGH;
            half_cnt             <= baud_divider;
            serial_clock_pin_out <= 1'b1;
          end else begin
            half_cnt <= half_cnt - `SSR_ONE_BYTE;
          end
        end
        default: begin
          state                <= ST_IDLE;
          half_cnt             <= `SSR_RST_BYTE;
          serial_clock_pin_out <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Shift registers and bit counter.
  // ************************************************************
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_prev               <= 1'b0;
      bit_cnt                <= `SSR_RST_CNT;
      receive_shift_register <= `SSR_RST_CHAR;
    end else begin
      clk_prev <= clk_s;
      if (!active) begin
        bit_cnt <= `SSR_RST_CNT;
      end else if (trail) begin
        bit_cnt <= char_done ? `SSR_RST_CNT : bit_cnt + `SSR_ONE_CNT;
      end
      if (trail && rx_mode) begin
        receive_shift_register <= next_rsr;
      end
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      transmit_buffer         <= `SSR_RST_CHAR;
      tx_buf_full             <= 1'b0;
      transmit_shift_register <= `SSR_RST_CHAR;
      tsr_full                <= 1'b0;
      bidir_data_pin_out      <= 1'b0;
    end else if (!serial_port_enable) begin
      tx_buf_full        <= 1'b0;
      tsr_full           <= 1'b0;
      bidir_data_pin_out <= 1'b0;
    end else begin
      if (wr_buf) begin
        transmit_buffer <= {transmit_ninth_bit, pwdata[7:0]};
        tx_buf_full     <= 1'b1;
      end else if (tx_load) begin
        tx_buf_full <= 1'b0;
      end
      if (tx_load) begin
        transmit_shift_register <= transmit_buffer;
        tsr_full                <= 1'b1;
      end else if (tx_done) begin
        tsr_full <= 1'b0;
      end else if (lead && !rx_mode) begin
        bidir_data_pin_out      <= transmit_shift_register[0];
        transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
      end
    end
  end

  // ************************************************************
  // Read data, captured in the setup cycle.
  // ************************************************************
  always @* begin
    next_prdata = `SSR_RST_WORD;
    case (paddr)
      `SSR_A_IRQ_EN:  next_prdata[7:0] = peripheral_irq_enable;
      `SSR_A_IRQ_FLG: begin
        next_prdata[`SSR_IF_RC] = receive_ready_flag;
        next_prdata[`SSR_IF_TX] = transmit_ready_flag;
      end
      `SSR_A_RX_DATA: next_prdata[7:0] = fifo_head[7:0];
      `SSR_A_RX_CTL: begin
        next_prdata[`SSR_RC_SERIAL_PORT_ENABLE]  = serial_port_enable;
        next_prdata[`SSR_RC_RX9]   = nine_bit_receive_select;
        next_prdata[`SSR_RC_SINGLE_RECEIVE_ENABLE]  = single_receive_enable;
        next_prdata[`SSR_RC_CONTINUOUS_RECEIVE_ENABLE]  = continuous_receive_enable;
        next_prdata[`SSR_RC_ADDRESS_DETECT_ENABLE] = address_detect_enable;
        next_prdata[`SSR_RC_OVERRUN_FLAG]  = overrun_flag;
        next_prdata[`SSR_RC_RECEIVED_NINTH_BIT]  = fifo_head[8];
      end
      `SSR_A_TX_CTL: begin
        next_prdata[`SSR_TC_CLOCK_SOURCE_SELECT] = clock_source_select;
        next_prdata[`SSR_TC_TX9]  = nine_bit_transmit_select;
        next_prdata[`SSR_TC_TRANSMIT_ENABLE] = transmit_enable;
        next_prdata[`SSR_TC_SYNC] = sync_select;
        next_prdata[`SSR_TC_BAUD_SPEED_SELECT] = baud_speed_select;
        next_prdata[`SSR_TC_TRMT] = !tsr_full;
        next_prdata[`SSR_TC_TRANSMIT_NINTH_BIT] = transmit_ninth_bit;
      end
      `SSR_A_BAUD:    next_prdata[7:0] = baud_divider;
      `SSR_A_IRQ_CTL: begin
        next_prdata[`SSR_IC_GIE]  = global_irq_enable;
        next_prdata[`SSR_IC_PERIPHERAL_IRQ_MASTER_ENABLE] = peripheral_irq_master_enable;
      end
      default:        next_prdata = `SSR_RST_WORD;
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= `SSR_RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule

// >>> test/ssr_port_monitor.sv
`timescale 1ns/10ps
// ****************************************
// Checker of the port pins and bus.
// ****************************************
module ssr_port_monitor (
  input wire        sys_clk,
  input wire        rstn,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        bidir_data_pin_oe,
  input wire        serial_clock_pin_out,
  input wire        serial_clock_pin_oe,
  input wire        irq
);
  reg  [7:0] rc;
  reg  [7:0] tc;
  reg  [7:0] ie;
  reg  [7:0] ic;
  reg  [7:0] nclk;
  reg        ckq;
  wire       wr  = psel && penable && pwrite;
  wire       wrc = wr && paddr == 8'h0c;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rc <= 8'h00;
      tc <= 8'h00;
      ie <= 8'h00;
      ic <= 8'h00;
      nclk <= 8'h00;
      ckq <= 1'b0;
    end else begin
      ckq <= serial_clock_pin_out;
      if (wrc)
        rc <= pwdata[7:0];
      if (wr && paddr == 8'h10)
        tc <= pwdata[7:0];
      if (wr && paddr == 8'h00)
        ie <= pwdata[7:0];
      if (wr && paddr == 8'h1c)
        ic <= pwdata[7:0];
      if (wrc)
        nclk <= 8'h00;
      else if (serial_clock_pin_out && !ckq)
        nclk <= nclk + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_bad_addr: assert property (psel && penable && paddr > 8'h1c |-> pslverr) else $error("no slave error");
  a_err_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rx_release: assert property (rc[7] && tc[4] && tc[7] && (rc[5] || rc[4]) |-> !bidir_data_pin_oe)
    else $error("data driven in receive");
  a_slave_clock: assert property (rc[7] && tc[4] && !tc[7] |-> !serial_clock_pin_oe)
    else $error("slave drives clock");
  a_master_clock: assert property (rc[7] && tc[4] && tc[7] |-> serial_clock_pin_oe)
    else $error("master clock not driven");
  a_stop_clock: assert property (wrc && pwdata[5:4] == 2'h0 |-> ##2 !serial_clock_pin_out [*8])
    else $error("clock runs after stop");
  a_bit_count: assert property (rc[5] && !rc[4] && tc[7] |-> nclk <= (rc[6] ? 8'h09 : 8'h08))
    else $error("too many clocks");
  a_port_off: assert property (wrc && !pwdata[7] |-> ##2 !irq)
    else $error("irq after port off");
  a_irq_gate: assert property (!ic[6] || ie[5:4] == 2'h0 |-> !irq)
    else $error("irq not gated");
  c_clock: cover property (serial_clock_pin_out && serial_clock_pin_oe);
  c_irq: cover property (irq);
  c_err: cover property (psel && penable && pslverr);
endmodule
bind ssr_port ssr_port_monitor mon (
  .sys_clk              (sys_clk),
  .rstn                 (rstn),
  .paddr                (paddr),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .pwdata               (pwdata),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .bidir_data_pin_oe    (bidir_data_pin_oe),
  .serial_clock_pin_out (serial_clock_pin_out),
  .serial_clock_pin_oe  (serial_clock_pin_oe),
  .irq                  (irq)
);

// >>> test/ssr_far_end.sv
`timescale 1ns/10ps
// ****************************************
// Far end on the data and clock lines.
// ****************************************
module ssr_far_end (
  input  wire        ck,
  input  wire        dat,
  input  wire        mst,
  input  wire        go,
  input  wire [26:0] pat,
  output reg         line_ck,
  output reg         line_dat,
  output reg         busy,
  output reg  [7:0]  got
);
  reg     [26:0] sh;
  integer        i;
  initial begin
    line_ck = 1'b0;
    line_dat = 1'b1;
    busy = 1'b0;
    got = 8'h00;
  end
  // Bits go out LSB first on the leading edge; spent bits refill inverted.
  always @(posedge ck) begin
    if (!mst) begin
      line_dat <= sh[0];
      sh <= {~sh[0], sh[26:1]};
    end
  end
  // As master it gives exactly eight clocks of 80 ns, then holds the clock low.
  always @(posedge go) begin
    sh = pat;
    if (mst) begin
      busy = 1'b1;
      #3;
      for (i = 0; i < 8; i = i + 1) begin
        line_ck = 1'b1;
        line_dat = sh[0];
        sh = {~sh[0], sh[26:1]};
        #40;
        line_ck = 1'b0;
        got = {dat, got[7:1]};
        #40;
      end
      line_dat = ~line_dat;
      busy = 1'b0;
    end
  end
endmodule

// >>> test/sync_serial_rx_and_slave_port_bench.sv
`timescale 1ns/10ps
// ****************************************
// Bench of the synchronous serial port.
// ****************************************
module sync_serial_rx_and_slave_port_bench;
  reg         sys_clk;
  reg         rstn;
  reg  [7:0]  paddr;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        bidir_data_pin_out;
  wire        bidir_data_pin_oe;
  wire        serial_clock_pin_out;
  wire        serial_clock_pin_oe;
  wire        irq;
  wire        far_ck;
  wire        far_dat;
  wire        far_busy;
  wire [7:0]  far_got;
  wire        dat_line = bidir_data_pin_oe ? bidir_data_pin_out : far_dat;
  wire        ck_line = serial_clock_pin_oe ? serial_clock_pin_out : far_ck;
  reg         mst;
  reg         go;
  reg  [26:0] pat;
  reg  [31:0] rd;
  reg         er;
  integer     n_mismatch;
  integer     total_checks;
  integer     cyc;
  ssr_port dut (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .paddr                (paddr),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .bidir_data_pin_in    (dat_line),
    .bidir_data_pin_out   (bidir_data_pin_out),
    .bidir_data_pin_oe    (bidir_data_pin_oe),
    .serial_clock_pin_in  (ck_line),
    .serial_clock_pin_out (serial_clock_pin_out),
    .serial_clock_pin_oe  (serial_clock_pin_oe),
    .irq                  (irq)
  );
  ssr_far_end far (.ck(ck_line), .dat(dat_line), .mst(mst), .go(go), .pat(pat),
    .line_ck(far_ck), .line_dat(far_dat), .busy(far_busy), .got(far_got));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end
  task finish_test;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task wait_rd(input [7:0] a, input [7:0] m);
    integer k;
    begin
      rd = 32'h0;
      for (k = 0; k < 400 && (rd[7:0] & m) !== m; k = k + 1)
        apb(1'b0, a, 32'h0);
    end
  endtask
  task load(input m, input [26:0] p);
    begin
      mst <= m;
      pat <= p;
      @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
    end
  endtask
  task t_reset;
    begin
      rdc(8'h0c, 32'h00);
      rdc(8'h10, 32'h02);
      rdc(8'h08, 32'h00);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
    end
  endtask
  task t_single;
    begin
      // Rate, then mode and enable, address detect clear, then start.
      wr(8'h18, 8'h03);
      wr(8'h10, 8'h90);
      wr(8'h0c, 8'h80);
      load(1'b0, 27'ha5);
      wr(8'h0c, 8'ha0);
      wait_rd(8'h04, 8'h20);
      rdc(8'h0c, 32'h80);
      rdc(8'h08, 32'ha5);
      rdc(8'h04, 32'h00);
    end
  endtask
  task t_nine;
    begin
      load(1'b0, 27'h13c);
      wr(8'h0c, 8'hc0);
      wr(8'h0c, 8'he0);
      wait_rd(8'h04, 8'h20);
      // The ninth bit is read before the low byte.
      rdc(8'h0c, 32'hc1);
      rdc(8'h08, 32'h3c);
    end
  endtask
  task t_overrun;
    begin
      wr(8'h00, 8'h20);
      wr(8'h1c, 8'h40);
      load(1'b0, 27'h00fc35a);
      wr(8'h0c, 8'h90);
      wait_rd(8'h0c, 8'h02);
      chk({31'h0, irq}, 32'h1);
      rdc(8'h08, 32'h5a);
      rdc(8'h0c, 32'h92);
      rdc(8'h08, 32'hc3);
      rdc(8'h04, 32'h00);
      wr(8'h0c, 8'h00);
      rdc(8'h0c, 32'h00);
    end
  endtask
  task t_abort;
    begin
      wr(8'h0c, 8'h80);
      load(1'b0, 27'h0ff);
      wr(8'h0c, 8'h90);
      repeat (12) @(posedge sys_clk);
      wr(8'h0c, 8'h80);
      repeat (60) @(posedge sys_clk);
      rdc(8'h04, 32'h00);
    end
  endtask
  task t_slave_rx;
    begin
      wr(8'h10, 8'h10);
      wr(8'h0c, 8'h90);
      load(1'b1, 27'h96);
      wait_rd(8'h04, 8'h20);
      rdc(8'h08, 32'h96);
      wr(8'h0c, 8'h80);
    end
  endtask
  task t_slave_tx;
    begin
      // Transmit enabled first, then the two bytes.
      wr(8'h10, 8'h30);
      wr(8'h00, 8'h10);
      wr(8'h14, 8'h3c);
      wr(8'h14, 8'ha7);
      rdc(8'h04, 32'h00);
      rdc(8'h10, 32'h30);
      load(1'b1, 27'h0);
      wait_rd(8'h04, 8'h10);
      wait (far_busy == 1'b0);
      chk({24'h0, far_got}, 32'h3c);
      chk({31'h0, irq}, 32'h1);
    end
  endtask
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mst = 1'b0;
    go = 1'b0;
    pat = 27'h0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_single;
    t_nine;
    t_overrun;
    t_abort;
    t_slave_rx;
    t_slave_tx;
    finish_test;
  end
endmodule
